// ### shared/eas_cfg.svh
/*
 * Constants of the port 2 EEE status and next-page control register bank:
 * register indices, field positions, reset values and timing counts.
 * Assumes a 32-bit AHB-Lite bus; byte address = register index * 4.
 */
`ifndef EAS_CFG_SVH
`define EAS_CFG_SVH

// Register indices (byte address is index * 4)
`define EAS_IDX_W 10
`define EAS_IDX_STATUS 10'h0f0
`define EAS_IDX_RECOV 10'h0f2
`define EAS_IDX_NPCTL 10'h0f3
`define EAS_IDX_IRQ_STAT 10'h100
`define EAS_IDX_IRQ_MASK 10'h101

// Status and auto-negotiation expansion fields
`define EAS_B_RX_LPI_LATCH 11
`define EAS_B_RX_LPI_LIVE 10
`define EAS_B_RSV_HI 9
`define EAS_B_RSV_LO 8
`define EAS_B_NP_LOC_ABLE 6
`define EAS_B_NP_LOC 5
`define EAS_B_PD_FAULT 4
`define EAS_B_LP_NP_ABLE 3
`define EAS_B_NP_ABLE 2
`define EAS_B_PAGE_RX 1
`define EAS_B_LP_AN_ABLE 0
`define EAS_NP_LOC_ABLE_VAL 1'h1
`define EAS_NP_LOC_VAL 1'h1
`define EAS_NP_ABLE_VAL 1'h1
`define EAS_RSV_RST 2'h0

// Next-page control fields
`define EAS_B_NP_EN_P2 1
`define EAS_B_NP_EN_P1 0
`define EAS_NPCTL_RST 2'h3

// Recovery counter
`define EAS_RECOV_W 8
`define EAS_RECOV_RST 8'h27
`define EAS_RECOV_UNIT_NS 640
`define EAS_CLK_NS 10
`define EAS_RECOV_UNIT_CYC ((`EAS_RECOV_UNIT_NS + `EAS_CLK_NS - 1) / `EAS_CLK_NS)

// Interrupt status and mask layout
`define EAS_IRQ_W 4
`define EAS_IRQ_RX_LPI 0
`define EAS_IRQ_PD_FAULT 1
`define EAS_IRQ_PAGE_RX 2
`define EAS_IRQ_RECOV_DONE 3
`define EAS_IRQ_RST 4'h0

`endif

// ### shared/eas_pkg.sv
/*
 * Types of the port 2 EEE status and next-page control register bank.
 * Assumes eas_cfg.svh for all numeric constants.
 */
package eas_pkg;

    typedef enum logic [1:0] {
        EAS_TRANS_IDLE = 2'h0,
        EAS_TRANS_BUSY = 2'h1,
        EAS_TRANS_NONSEQ = 2'h2,
        EAS_TRANS_SEQ = 2'h3
    } eas_htrans_t;

    typedef enum logic [1:0] {
        EAS_RT_IDLE = 2'b01,
        EAS_RT_WAIT = 2'b10
    } eas_rt_state_t;

endpackage : eas_pkg

// ### src/eas_recovery_timer.sv
/*
 * Wake recovery timer: after low-power idle ends, holds the MAC transmitter
 * off for the programmed number of units, each unit UNIT_CYC clock cycles.
 * Assumes a synchronous, active-low reset and a one-cycle exit pulse.
 */
`timescale 1ns/1ns
`include "eas_cfg.svh"

module eas_recovery_timer
    import eas_pkg::*;
#(
    parameter int CNT_W = `EAS_RECOV_W,
    parameter int UNIT_CYC = `EAS_RECOV_UNIT_CYC
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Control
    input wire logic start,
    input wire logic [CNT_W-1:0] units,
    // Status
    output logic hold,
    output logic done
);

    localparam int SUB_W = (UNIT_CYC > 1) ? $clog2(UNIT_CYC) : 1;
    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(UNIT_CYC - 1);

    eas_rt_state_t state_q;
    logic [CNT_W-1:0] unit_q;
    logic [SUB_W-1:0] sub_q;
    logic last_tick;

    assign last_tick = (sub_q == SUB_LAST) && (unit_q == CNT_W'(1));
    assign hold = (state_q == EAS_RT_WAIT);

    ////////////////////////////////////////////////////////////////////////
    // Sequencing

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            state_q <= EAS_RT_IDLE;
            unit_q <= '0;
            sub_q <= '0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            case (state_q)
                EAS_RT_IDLE:
                begin
                    // A zero count releases the MAC at once
                    if (start && (units != '0))
                    begin
                        state_q <= EAS_RT_WAIT;
                        unit_q <= units;
                        sub_q <= '0;
                    end
                    else if (start)
                    begin
                        done <= 1'b1;
                    end
                end
                EAS_RT_WAIT:
                begin
                    if (last_tick)
                    begin
                        state_q <= EAS_RT_IDLE;
                        done <= 1'b1;
                    end
                    else if (sub_q == SUB_LAST)
                    begin
                        sub_q <= '0;
                        unit_q <= unit_q - CNT_W'(1);
                    end
                    else
                    begin
                        sub_q <= sub_q + SUB_W'(1);
                    end
                end
                default:
                begin
                    state_q <= EAS_RT_IDLE;
                end
            endcase
        end
    end

endmodule : eas_recovery_timer

// ### src/eas_regs.sv
/*
 * Port 2 EEE status / auto-negotiation expansion, LPI recovery counter and
 * next-page control registers behind an AHB-Lite slave, with an interrupt.
 * Assumes PHY-side status inputs synchronous to sys_clk, event inputs one
 * cycle wide, and a single bus master with word accesses.
 */
// Added by the designer: the AHB-Lite slave port.
// How it works
// - Receive LPI sets latched bit 11, held.
// - Writing one clears bit 11; set wins.
// - Bit 10 follows receive LPI live.
// - Bit 6 always reads one.
// - Bit 5 reads one: pages at 0x0EA.
// - Parallel fault latches bit 4; read clears.
// - Bit 3 shows partner next-page ability.
// - Bit 2 shows local next-page ability, one.
// - New page latches bit 1 high.
// - Bit 0 shows partner auto-negotiation ability.
// - MAC waits count times 640 ns after LPI.
// - Port 2 next-page enable gates exchange.
// - Port 1 next-page enable gates exchange.
`timescale 1ns/1ns
`include "eas_cfg.svh"

module eas_regs
    import eas_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int RECOV_UNIT_CYC = `EAS_RECOV_UNIT_CYC
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // PHY and auto-negotiation status
    input wire logic rx_lpi_active,
    input wire logic pd_fault_evt,
    input wire logic page_rx_evt,
    input wire logic partner_np_able,
    input wire logic partner_an_able,
    input wire logic lpi_exit,
    // Controls to the port logic
    output logic mac_tx_hold,
    output logic np_exchange_en_p1,
    output logic np_exchange_en_p2,
    // Interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Word index from a byte address; the two low bits are dropped
    function automatic logic [`EAS_IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[`EAS_IDX_W+1:2];
    endfunction : reg_index

    // Latched flag: a set in the same cycle as a clear wins,
    // so no event is lost
    function automatic logic sticky(input logic cur, input logic set, input logic clr);
        sticky = set | (cur & ~clr);
    endfunction : sticky

    ////////////////////////////////////////////////////////////////////////
    // Bus phase tracking

    logic addr_ok;
    logic wr_req;
    logic rd_req;
    logic wr_pend_q;
    logic [`EAS_IDX_W-1:0] wr_idx_q;
    logic wr_do;
    logic rd_do;
    logic [`EAS_IDX_W-1:0] rd_idx;
    logic [15:0] stat_rd;

    // Only word-sized NONSEQ or SEQ transfers are taken; other sizes
    // and idle or busy slots leave every register untouched
    assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'h2);
    assign wr_req = addr_ok && hwrite;
    assign rd_req = addr_ok && !hwrite;
    // A read behind a pending write waits one cycle so it sees the new value
    assign hreadyout = !(wr_pend_q && hsel && htrans[1] && !hwrite);
    // Every transfer completes OKAY; there is no error response
    assign hresp = 1'b0;
    assign wr_do = wr_pend_q;
    assign rd_do = rd_req && hreadyout;
    assign rd_idx = reg_index(haddr);

    // A write commits one edge after its address phase, when hwdata
    // is valid; the index is kept for that data phase
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= '0;
        end
        else
        begin
            if (wr_req && hreadyout)
            begin
                wr_pend_q <= 1'b1;
                wr_idx_q <= reg_index(haddr);
            end
            else
            begin
                wr_pend_q <= 1'b0;
            end
        end
    end

    // One strobe for each register
    logic wr_status;
    logic wr_recov;
    logic wr_npctl;
    logic wr_irq_stat;
    logic wr_irq_mask;
    logic rd_status;

    assign wr_status = wr_do && (wr_idx_q == `EAS_IDX_STATUS);
    assign wr_recov = wr_do && (wr_idx_q == `EAS_IDX_RECOV);
    assign wr_npctl = wr_do && (wr_idx_q == `EAS_IDX_NPCTL);
    assign wr_irq_stat = wr_do && (wr_idx_q == `EAS_IDX_IRQ_STAT);
    assign wr_irq_mask = wr_do && (wr_idx_q == `EAS_IDX_IRQ_MASK);
    assign rd_status = rd_do && (rd_idx == `EAS_IDX_STATUS);

    ////////////////////////////////////////////////////////////////////////
    // Status and auto-negotiation expansion

    // Bit 11 is set from the live level, so a clear written while LPI
    // is still present does not stick
    // Bits 4 and 1 clear on a status read; an event in the same cycle
    // survives the read and shows on the next one
    // Bits 9:8 are plain storage with no effect on the port
    logic rx_lpi_latch_q;
    logic pd_fault_q;
    logic page_rx_q;
    logic [1:0] rsv_q;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            rx_lpi_latch_q <= 1'b0;
            pd_fault_q <= 1'b0;
            page_rx_q <= 1'b0;
            rsv_q <= `EAS_RSV_RST;
        end
        else
        begin
            rx_lpi_latch_q <= sticky(rx_lpi_latch_q, rx_lpi_active,
                wr_status && hwdata[`EAS_B_RX_LPI_LATCH]);
            // Event inputs are one-cycle pulses from the port logic
            pd_fault_q <= sticky(pd_fault_q, pd_fault_evt, rd_status);
            page_rx_q <= sticky(page_rx_q, page_rx_evt, rd_status);
            if (wr_status)
            begin
                rsv_q <= hwdata[`EAS_B_RSV_HI:`EAS_B_RSV_LO];
            end
        end
    end

    // Latched and stored bits, live inputs and constants; bits 15..12 and 7 read zero
    always_comb
    begin
        stat_rd = 16'h0000;
        stat_rd[`EAS_B_RX_LPI_LATCH] = rx_lpi_latch_q;
        stat_rd[`EAS_B_RX_LPI_LIVE] = rx_lpi_active;
        stat_rd[`EAS_B_RSV_HI:`EAS_B_RSV_LO] = rsv_q;
        stat_rd[`EAS_B_NP_LOC_ABLE] = `EAS_NP_LOC_ABLE_VAL;
        stat_rd[`EAS_B_NP_LOC] = `EAS_NP_LOC_VAL;
        stat_rd[`EAS_B_PD_FAULT] = pd_fault_q;
        stat_rd[`EAS_B_LP_NP_ABLE] = partner_np_able;
        stat_rd[`EAS_B_NP_ABLE] = `EAS_NP_ABLE_VAL;
        stat_rd[`EAS_B_PAGE_RX] = page_rx_q;
        stat_rd[`EAS_B_LP_AN_ABLE] = partner_an_able;
    end

    ////////////////////////////////////////////////////////////////////////
    // Recovery counter and next-page control

    // A new count applies from the next exit from LPI; a wait already
    // running keeps the count it started with
    // The enables reach the port logic as plain levels; clearing one
    // takes effect at the next auto-negotiation
    logic [`EAS_RECOV_W-1:0] recov_q;
    logic [1:0] np_en_q;
    logic recov_done;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            recov_q <= `EAS_RECOV_RST;
            np_en_q <= `EAS_NPCTL_RST;
        end
        else
        begin
            if (wr_recov)
            begin
                recov_q <= hwdata[`EAS_RECOV_W-1:0];
            end
            if (wr_npctl)
            begin
                np_en_q <= hwdata[`EAS_B_NP_EN_P2:`EAS_B_NP_EN_P1];
            end
        end
    end

    assign np_exchange_en_p2 = np_en_q[`EAS_B_NP_EN_P2];
    assign np_exchange_en_p1 = np_en_q[`EAS_B_NP_EN_P1];

    // The MAC is held off from the edge after the exit pulse
    eas_recovery_timer #(
        .CNT_W(`EAS_RECOV_W),
        .UNIT_CYC(RECOV_UNIT_CYC)
    ) u_recov (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(lpi_exit),
        .units(recov_q),
        .hold(mac_tx_hold),
        .done(recov_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask

    // Receive LPI raises its event on the rising edge only, so one long
    // LPI period gives one interrupt
    // Status bits are write-one-to-clear; the mask only gates irq
    logic rx_lpi_prev_q;
    logic [`EAS_IRQ_W-1:0] irq_stat_q;
    logic [`EAS_IRQ_W-1:0] irq_mask_q;
    logic [`EAS_IRQ_W-1:0] irq_evt;

    always_comb
    begin
        irq_evt = `EAS_IRQ_RST;
        irq_evt[`EAS_IRQ_RX_LPI] = rx_lpi_active && !rx_lpi_prev_q;
        irq_evt[`EAS_IRQ_PD_FAULT] = pd_fault_evt;
        irq_evt[`EAS_IRQ_PAGE_RX] = page_rx_evt;
        irq_evt[`EAS_IRQ_RECOV_DONE] = recov_done;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            rx_lpi_prev_q <= 1'b0;
            irq_stat_q <= `EAS_IRQ_RST;
            irq_mask_q <= `EAS_IRQ_RST;
        end
        else
        begin
            rx_lpi_prev_q <= rx_lpi_active;
            // New events win over a same-cycle write-one clear
            irq_stat_q <= irq_evt |
                (irq_stat_q & ~(wr_irq_stat ? hwdata[`EAS_IRQ_W-1:0] : `EAS_IRQ_RST));
            if (wr_irq_mask)
            begin
                irq_mask_q <= hwdata[`EAS_IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured at the address phase

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            hrdata <= 32'h0000_0000;
        end
        // Loaded once per accepted read, at the same edge at which the
        // read-clear flags drop, so the old value is the one returned
        else if (rd_do)
        begin
            case (rd_idx)
                `EAS_IDX_STATUS: hrdata <= {16'h0000, stat_rd};
                `EAS_IDX_RECOV: hrdata <= {24'h00_0000, recov_q};
                `EAS_IDX_NPCTL: hrdata <= {30'h0000_0000, np_en_q};
                `EAS_IDX_IRQ_STAT: hrdata <= {28'h000_0000, irq_stat_q};
                `EAS_IDX_IRQ_MASK: hrdata <= {28'h000_0000, irq_mask_q};
                // Unmapped indices read zero
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule : eas_regs

// ### tb/eas_regs_properties.sv
/* Port assertions for the EEE status register bank.
   Assumes a bind from the testbench and a timer unit of at least 2 cycles. */
`timescale 1ns/1ns
`include "eas_cfg.svh"
module eas_regs_properties
#(
    parameter int ADDR_W = 32
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Bus
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    // Link status and controls
    input wire logic rx_lpi_active,
    input wire logic pd_fault_evt,
    input wire logic page_rx_evt,
    input wire logic partner_np_able,
    input wire logic partner_an_able,
    input wire logic lpi_exit,
    input wire logic mac_tx_hold,
    input wire logic np_exchange_en_p1,
    input wire logic np_exchange_en_p2
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    sequence s_rd_st;
        hsel && hready && htrans[1] && !hwrite && hsize == 3'h2
            && haddr[11:2] == `EAS_IDX_STATUS;
    endsequence
    sequence s_wr_np;
        hsel && hready && htrans[1] && hwrite && hsize == 3'h2
            && haddr[11:2] == `EAS_IDX_NPCTL ##1 hreadyout;
    endsequence
    ////////////////////////////////////////
    a_lpi_latch_set: assert property (rx_lpi_active ##1 s_rd_st |=> hrdata[11])
        else $error("latched rx lpi bit clear");
    a_lpi_live_bit: assert property ($stable(rx_lpi_active) ##0 s_rd_st
        |=> hrdata[10] == $past(rx_lpi_active)) else $error("live lpi bit wrong");
    a_const_bits: assert property (s_rd_st |=> hrdata[6:5] == 2'h3 && hrdata[2])
        else $error("constant status bits wrong");
    a_fault_rd_clear: assert property (s_rd_st ##0 !pd_fault_evt ##1 !pd_fault_evt
        ##1 s_rd_st ##0 !pd_fault_evt |=> !hrdata[4]) else $error("fault bit not cleared");
    a_page_rd_clear: assert property (s_rd_st ##0 !page_rx_evt ##1 !page_rx_evt
        ##1 s_rd_st ##0 !page_rx_evt |=> !hrdata[1]) else $error("page bit not cleared");
    a_partner_bits: assert property ($stable(partner_np_able) && $stable(partner_an_able)
        ##0 s_rd_st |=> hrdata[3] == $past(partner_np_able)
        && hrdata[0] == $past(partner_an_able)) else $error("partner bits wrong");
    a_hold_cause: assert property ($rose(mac_tx_hold) |-> $past(lpi_exit) ##0 mac_tx_hold[*2])
        else $error("hold without lpi exit or too short");
    a_np_en_write: assert property (s_wr_np |=> np_exchange_en_p2 == $past(hwdata[1])
        && np_exchange_en_p1 == $past(hwdata[0])) else $error("np enable not written");
    a_one_wait: assert property (!hreadyout |=> hreadyout)
        else $error("more than one wait state");
endmodule : eas_regs_properties

// ### tb/eas_link_partner.sv
/* Behavioural remote link partner: LPI, page and fault events.
   Assumes bench commands change just after a rising edge. */
`timescale 1ns/1ns
module eas_link_partner
(
    // Clock
    input wire logic sys_clk,
    // Commands
    input wire logic lpi_on,
    input wire logic fault_req,
    input wire logic page_req,
    input wire logic np_able,
    input wire logic an_able,
    // Toward the device
    output logic rx_lpi_active,
    output logic pd_fault_evt,
    output logic page_rx_evt,
    output logic partner_np_able,
    output logic partner_an_able,
    output logic lpi_exit
);
    initial
    begin
        {rx_lpi_active, pd_fault_evt, page_rx_evt} = 3'h0;
        {partner_np_able, partner_an_able, lpi_exit} = 3'h0;
    end
    always @(posedge sys_clk)
    begin
        rx_lpi_active <= lpi_on;
        lpi_exit <= rx_lpi_active && !lpi_on; // One pulse as LPI ends
        pd_fault_evt <= fault_req;
        page_rx_evt <= page_req;
        partner_np_able <= np_able;
        partner_an_able <= an_able;
    end
endmodule : eas_link_partner

// ### tb/testbench.sv
/* Self-checking bench for the register bank over AHB-Lite.
   Assumes the timer unit shortened to 2 cycles. */
`timescale 1ns/1ns
`include "eas_cfg.svh"
module testbench
    import eas_pkg::*;
;
    localparam logic [31:0] A_ST = `EAS_IDX_STATUS * 4;
    localparam logic [31:0] A_RC = `EAS_IDX_RECOV * 4;
    localparam logic [31:0] A_NP = `EAS_IDX_NPCTL * 4;
    localparam logic [31:0] A_IS = `EAS_IDX_IRQ_STAT * 4;
    localparam logic [31:0] A_IM = `EAS_IDX_IRQ_MASK * 4;
    logic sys_clk, nrst, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic lpi_on, fault_req, page_req, np_able, an_able;
    logic rx_lpi_active, pd_fault_evt, page_rx_evt, partner_np_able, partner_an_able;
    logic lpi_exit, mac_tx_hold, en_p1, en_p2;
    int err_total = 0;
    int checks_done = 0;
    int hold_cnt = 0;
    assign hready = hreadyout;
    ////////////////////////////////////////
    eas_regs #(.ADDR_W(32), .RECOV_UNIT_CYC(2)) dut (.sys_clk(sys_clk), .nrst(nrst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rx_lpi_active(rx_lpi_active), .pd_fault_evt(pd_fault_evt),
        .page_rx_evt(page_rx_evt), .partner_np_able(partner_np_able),
        .partner_an_able(partner_an_able), .lpi_exit(lpi_exit), .mac_tx_hold(mac_tx_hold),
        .np_exchange_en_p1(en_p1), .np_exchange_en_p2(en_p2), .irq(irq));
    eas_link_partner u_lp (.sys_clk(sys_clk), .lpi_on(lpi_on), .fault_req(fault_req),
        .page_req(page_req), .np_able(np_able), .an_able(an_able),
        .rx_lpi_active(rx_lpi_active), .pd_fault_evt(pd_fault_evt),
        .page_rx_evt(page_rx_evt), .partner_np_able(partner_np_able),
        .partner_an_able(partner_an_able), .lpi_exit(lpi_exit));
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
        if (mac_tx_hold === 1'b1)
            hold_cnt <= hold_cnt + 1;
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= EAS_TRANS_NONSEQ;
        hwrite <= w;
        haddr <= a;
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= EAS_TRANS_IDLE;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask : rd
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    ////////////////////////////////////////
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        {lpi_on, fault_req, page_req, np_able, an_able} = 5'h0;
        nrst = 1'b0;
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rd(A_ST, 32'h64);
        rd(A_RC, 32'h27);
        rd(A_NP, 32'h3);
        rd(A_IM, 32'h0);
        wr(32'h3c4, 32'hffffffff);
        rd(32'h3c4, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        hsize <= 3'h1;
        wr(A_RC, 32'h55);
        hsize <= 3'h2;
        rd(A_RC, 32'h27);
        $display("test reset done");
        np_able <= 1'b1;
        an_able <= 1'b1;
        wr(A_ST, 32'h300);
        rd(A_ST, 32'h36d);
        wr(A_RC, 32'h3);
        lpi_on <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(A_ST, 32'hf6d);
        wr(A_ST, 32'hb00);
        rd(A_ST, 32'hf6d);
        lpi_on <= 1'b0;
        repeat (20) @(posedge sys_clk);
        chk(32'(hold_cnt), 32'h6);
        rd(A_ST, 32'hb6d);
        wr(A_ST, 32'hb00);
        rd(A_ST, 32'h36d);
        $display("test lpi done");
        fault_req <= 1'b1;
        page_req <= 1'b1;
        @(posedge sys_clk);
        fault_req <= 1'b0;
        page_req <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd(A_ST, 32'h37f);
        rd(A_ST, 32'h36d);
        $display("test events done");
        rd(A_IS, 32'hf);
        chk({31'h0, irq}, 32'h0);
        wr(A_IM, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        wr(A_IS, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        rd(A_IS, 32'hd);
        $display("test irq done");
        wr(A_NP, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk({30'h0, en_p2, en_p1}, 32'h2);
        wr(A_NP, 32'h1);
        rd(A_NP, 32'h1);
        chk({30'h0, en_p2, en_p1}, 32'h1);
        $display("test np enable done");
        summarize();
    end
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        err_total++;
        summarize();
    end
endmodule : testbench
bind eas_regs eas_regs_properties #(.ADDR_W(ADDR_W)) u_props (.sys_clk(sys_clk),
    .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .rx_lpi_active(rx_lpi_active), .pd_fault_evt(pd_fault_evt),
    .page_rx_evt(page_rx_evt), .partner_np_able(partner_np_able),
    .partner_an_able(partner_an_able), .lpi_exit(lpi_exit), .mac_tx_hold(mac_tx_hold),
    .np_exchange_en_p1(np_exchange_en_p1), .np_exchange_en_p2(np_exchange_en_p2));
